// *** dv/fdo_rx_model.sv ***
// Clock receiver that times one output pin in synth cycles
`timescale 1ns/1ps
module fdo_rx_model (
  // Clock and pin
  input wire logic clk_sys,
  input wire logic pin,
  // Measured shape
  output int n_rise,
  output int high_cyc,
  output int period_cyc
);
  logic last = 1'b0;
  int age = 0;
  // Pure listener, never loads the pin
  always @(posedge clk_sys) begin
    last <= pin;
    age <= (pin && !last) ? 1 : age + 1;
    if (pin && !last) begin
      n_rise <= n_rise + 1;
      period_cyc <= age;
    end
    if (!pin && last) high_cyc <= age;
  end
endmodule : fdo_rx_model

// *** dv/fdo_sva.sv ***
// Port-level assertions for the divider and output stages
`timescale 1ns/1ps
module fdo_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Controls
  input wire logic [7:0] frdiv_adj_load,
  input wire logic stage4_source_select,
  input wire logic stage7_source_select,
  input wire logic [11:0] out_single_ended,
  input wire logic [11:0] out_comp_invert,
  // Outputs
  input wire logic [7:0] frdiv_tick,
  input wire logic [7:0] frdiv_phase_busy,
  input wire logic [11:0] true_output_pin,
  input wire logic [11:0] complement_output_pin
);
  logic rs_d;
  // Extra cycle so pins forced by reset do not read as edges
  always_ff @(posedge clk_sys) rs_d <= reset;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset || rs_d);
  sequence s_tick;
    frdiv_tick[2] || $past(frdiv_tick[2]) || $past(frdiv_tick[2], 2);
  endsequence
  property p_comp;
    complement_output_pin == (true_output_pin ^ ~($past(out_single_ended) & ~$past(out_comp_invert)));
  endproperty
  a_comp: assert property (p_comp) else $error("complement pin wrong");
  property p_dual; $changed(true_output_pin[1:0]) |-> $past(frdiv_tick[0]); endproperty
  a_dual: assert property (p_dual) else $error("stage 0 moved off tick");
  property p_s4;
    $changed(true_output_pin[8]) |-> $past(stage4_source_select ? frdiv_tick[5] : frdiv_tick[4]);
  endproperty
  a_s4: assert property (p_s4) else $error("stage 4 source wrong");
  property p_s5; $changed(true_output_pin[9]) |-> $past(frdiv_tick[5]); endproperty
  a_s5: assert property (p_s5) else $error("stage 5 source wrong");
  property p_s6; $changed(true_output_pin[10]) |-> $past(frdiv_tick[6]); endproperty
  a_s6: assert property (p_s6) else $error("stage 6 source wrong");
  property p_s7;
    $changed(true_output_pin[11]) |-> $past(stage7_source_select ? frdiv_tick[7] : frdiv_tick[6]);
  endproperty
  a_s7: assert property (p_s7) else $error("stage 7 source wrong");
  property p_busy_up; $rose(frdiv_phase_busy[2]) |-> $past(frdiv_adj_load[2]); endproperty
  a_busy_up: assert property (p_busy_up) else $error("busy without load");
  property p_busy_dn; $fell(frdiv_phase_busy[2]) |-> s_tick; endproperty
  a_busy_dn: assert property (p_busy_dn) else $error("busy cleared off period");
endmodule : fdo_sva
bind fdo_clock_gen fdo_sva i_sva (.clk_sys, .reset, .frdiv_adj_load, .stage4_source_select,
  .stage7_source_select, .out_single_ended, .out_comp_invert, .frdiv_tick, .frdiv_phase_busy,
  .true_output_pin, .complement_output_pin);

// *** dv/tb.sv ***
// Self-checking bench for the divider and output stages
`timescale 1ns/1ps
module tb;
  import fdo_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] frdiv_int [8];
  logic [42:0] frdiv_frac [8];
  logic signed [31:0] frdiv_adj_ps [8];
  logic [7:0] frdiv_adj_load = 8'h00;
  fdo_rate_t frdiv_rate [8];
  logic stage4_source_select = 1'b0;
  logic stage7_source_select = 1'b0;
  logic [31:0] out_div [12];
  logic [31:0] out_high [12];
  logic [11:0] out_single_ended = 12'h000;
  logic [11:0] out_comp_invert = 12'h000;
  logic [7:0] frdiv_tick;
  logic [7:0] frdiv_phase_busy;
  logic [11:0] true_output_pin;
  logic [11:0] complement_output_pin;
  int n_fail = 0;
  int samples_checked = 0;
  int n_rise [3];
  int high_cyc [3];
  int period_cyc [3];
  localparam int PIN [3] = '{0, 8, 11};
  fdo_clock_gen i_dut (.clk_sys, .reset, .frdiv_int, .frdiv_frac, .frdiv_adj_ps, .frdiv_adj_load,
    .frdiv_rate, .stage4_source_select, .stage7_source_select, .out_div, .out_high,
    .out_single_ended, .out_comp_invert, .frdiv_tick, .frdiv_phase_busy, .true_output_pin,
    .complement_output_pin);
  for (genvar m = 0; m < 3; m++) begin : g_rx
    fdo_rx_model i_rx (.clk_sys, .pin(true_output_pin[PIN[m]]), .n_rise(n_rise[m]),
      .high_cyc(high_cyc[m]), .period_cyc(period_cyc[m]));
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // Bounded, so a dead divider shows as a wrong count
  task automatic gap(input int g, output int n);
    repeat (99) if (frdiv_tick[g] !== 1'b1) @(negedge clk_sys);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (frdiv_tick[g] !== 1'b1 && n < 99);
  endtask : gap
  task automatic rises(input int m, input int k);
    int t;
    t = n_rise[m] + k;
    repeat (400) if (n_rise[m] < t) @(negedge clk_sys);
  endtask : rises
  task automatic t_ratio;
    int n;
    int s = 0;
    gap(1, n);
    for (int i = 0; i < 8; i++) begin
      gap(1, n);
      s += n;
    end
    chk(s, 114);
  endtask : t_ratio
  task automatic t_shape;
    rises(0, 2);
    chk(period_cyc[0], 56);
    chk(high_cyc[0], 28);
    out_div[0] = 32'h5;
    out_high[0] = 32'h1;
    rises(0, 3);
    chk(period_cyc[0], 70);
    chk(high_cyc[0], 14);
  endtask : t_shape
  task automatic t_comp;
    logic e;
    for (int m = 0; m < 3; m++) begin
      out_single_ended[0] = (m != 0);
      out_comp_invert[0] = (m == 2);
      repeat (20) @(negedge clk_sys);
      e = true_output_pin[0] ^ (m != 1);
      chk(complement_output_pin[0], e);
    end
  endtask : t_comp
  task automatic t_mux;
    for (int s = 0; s < 2; s++) begin
      stage4_source_select = s[0];
      stage7_source_select = s[0];
      rises(1, 2);
      rises(2, 2);
      chk(period_cyc[1], s ? 40 : 28);
      chk(period_cyc[2], s ? 40 : 28);
    end
  endtask : t_mux
  task automatic t_adjust;
    int n;
    int adj [4] = '{-400000, 150000, 50000, 200000};
    int len [4] = '{10, 15, 15, 16};
    fdo_rate_t rt [4] = '{FDO_RATE_FAST, FDO_RATE_SLOW, FDO_RATE_SLOW, FDO_RATE_MED};
    for (int i = 0; i < 4; i++) begin
      gap(2, n);
      frdiv_adj_ps[2] = adj[i];
      frdiv_rate[2] = rt[i];
      frdiv_adj_load[2] = 1'b1;
      @(negedge clk_sys);
      frdiv_adj_load[2] = 1'b0;
      chk(frdiv_phase_busy[2], 1'b1);
      gap(2, n);
      chk(n, len[i]);
      chk(frdiv_phase_busy[2], 1'b0);
    end
  endtask : t_adjust
  initial forever #50 clk_sys = ~clk_sys;
  initial begin
    #400us;
    n_fail++;
    wrap_up();
  end
  initial begin
    for (int i = 0; i < 8; i++) begin
      frdiv_int[i] = 8'h0E;
      frdiv_frac[i] = 43'h0;
      frdiv_adj_ps[i] = 32'sh0;
      frdiv_rate[i] = FDO_RATE_SLOW;
    end
    for (int i = 0; i < 12; i++) begin
      out_div[i] = (i > 7) ? 32'h2 : 32'h4;
      out_high[i] = 32'h0;
    end
    frdiv_frac[1] = 43'h200_0000_0000;
    frdiv_int[5] = 8'h14;
    frdiv_int[7] = 8'h14;
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    t_ratio();
    t_shape();
    t_comp();
    t_mux();
    t_adjust();
    wrap_up();
  end
endmodule : tb

// *** hdl/fdo_clock_gen.sv ***
// Fractional dividers and output divider stages
// Operation
// - Divide synth clock by integer plus 43-bit fraction over two to 43.
// - Integer part and fraction numerator are unsigned.
// - Divider output feeds output stages and loop feedback dividers.
// - Signed picosecond fine adjust; negative advances, positive delays edges.
// - Fine adjust raises or lowers frequency for a limited time.
// - Rate fast, medium or slow trades offset size against duration.
// - Fine adjustments accumulate without limit.
// - Stages 0-3 fixed; stage 4 picks 4/5, 7 picks 6/7, 5 and 6 fixed.
// - Dual stage has two identical paths fed from the same divider.
// - Each path divides divider clock by a 32-bit integer.
// - Without pulse width the output is half high, half low; odd divisors get one extra high tick.
// - Pulse shaping high time equals programmed 32-bit divider-cycle count.
// - Shaped pulses are always high going; invert the complement for low.
// - Duty and pulse width settings work in every output mode.
// - Single-ended complement copies true output, optionally inverted.
`timescale 1ns/1ps
`include "fdo_defines.svh"

module fdo_clock_gen #(
  parameter int INT_W = 8,
  parameter int ADJ_W = 32,
  parameter int PEND_W = 48
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Fractional divider ratio
  input wire logic [INT_W-1:0] frdiv_int [`FDO_NUM_DIV],
  input wire logic [`FDO_FRAC_W-1:0] frdiv_frac [`FDO_NUM_DIV],
  // Fine phase adjust
  input wire logic signed [ADJ_W-1:0] frdiv_adj_ps [`FDO_NUM_DIV],
  input wire logic [`FDO_NUM_DIV-1:0] frdiv_adj_load,
  input wire fdo_pkg::fdo_rate_t frdiv_rate [`FDO_NUM_DIV],
  // Stage source selection
  input wire logic stage4_source_select,
  input wire logic stage7_source_select,
  // Output path configuration
  input wire logic [31:0] out_div [`FDO_NUM_PATH],
  input wire logic [31:0] out_high [`FDO_NUM_PATH],
  input wire logic [`FDO_NUM_PATH-1:0] out_single_ended,
  input wire logic [`FDO_NUM_PATH-1:0] out_comp_invert,
  // Divider outputs
  output logic [`FDO_NUM_DIV-1:0] frdiv_tick,
  output logic [`FDO_NUM_DIV-1:0] frdiv_phase_busy,
  // Output pins
  output logic [`FDO_NUM_PATH-1:0] true_output_pin,
  output logic [`FDO_NUM_PATH-1:0] complement_output_pin
);
  import fdo_pkg::*;

  // Synth period in ps, the resolution of fine phase steps
  localparam logic [PEND_W-1:0] PERIOD_PS = PEND_W'(`FDO_SYNTH_PERIOD_PS);

  function automatic logic [2:0] step_cycles(input fdo_rate_t r);
    case (r)
      FDO_RATE_FAST: begin
        step_cycles = `FDO_STEP_FAST;
      end
      FDO_RATE_MED: begin
        step_cycles = `FDO_STEP_MED;
      end
      default: begin
        // Slow, and any unused code
        step_cycles = `FDO_STEP_SLOW;
      end
    endcase
  endfunction : step_cycles

  // Divider feeding each output path
  function automatic int path_source(input int p, input logic sel4, input logic sel7);
    if (p < `FDO_FIRST_SINGLE_PATH) begin
      // Dual stages, two paths per divider
      path_source = p / 2;
    end else if (p == `FDO_FIRST_SINGLE_PATH) begin
      // Stage 4 picks divider 4 or 5
      path_source = sel4 ? 5 : 4;
    end else if (p == `FDO_FIRST_SINGLE_PATH + 3) begin
      // Stage 7 picks divider 6 or 7
      path_source = sel7 ? 7 : 6;
    end else begin
      // Stages 5 and 6 are fixed
      path_source = p - `FDO_FIRST_SINGLE_PATH + 4;
    end
  endfunction : path_source

  // Output level for position cnt within a period
  function automatic logic path_level(input logic [31:0] cnt, input logic [31:0] div,
                                      input logic [31:0] high);
    logic [31:0] hi;
    if (high == 32'h0) begin
      // Odd divisors give the spare tick to the high phase
      hi = div - (div >> 1);
    end else begin
      hi = high;
    end
    // High while the position is inside the high phase
    path_level = cnt < hi;
  endfunction : path_level

  // One loop per kind of unit
  genvar g;

  // Fractional dividers
  generate
    for (g = 0; g < `FDO_NUM_DIV; g++) begin : gen_div
      // Period counter and fraction accumulator
      logic [INT_W:0] cnt;
      logic [INT_W:0] next_cnt;
      logic [`FDO_FRAC_W-1:0] acc;
      logic [`FDO_FRAC_W-1:0] next_acc;

      // Phase still to be applied
      logic signed [PEND_W-1:0] pend;
      logic signed [PEND_W-1:0] next_pend;
      logic tick;
      logic next_tick;

      // Working values for one period
      logic [`FDO_FRAC_W:0] sum;
      logic [PEND_W-1:0] mag;
      logic [PEND_W-1:0] step_amt;
      logic [2:0] adj_c;
      logic [INT_W+1:0] len;
      logic [INT_W+1:0] adj_len;
      logic carry;
      logic over_hi;
      logic over_lo;

      always_comb begin
        next_cnt = cnt;
        next_acc = acc;
        next_pend = pend;
        next_tick = 1'b0;
        // Unsigned accumulation, carry extends the period by one cycle
        sum = {1'b0, acc} + {1'b0, frdiv_frac[g]};
        carry = sum[`FDO_FRAC_W];
        if (pend[PEND_W-1]) begin
          mag = PEND_W'(-pend);
        end else begin
          mag = PEND_W'(pend);
        end
        // Fast takes big period offsets, slow small ones over more periods
        adj_c = step_cycles(frdiv_rate[g]);
        step_amt = PEND_W'(adj_c) * PERIOD_PS;
        if (mag < step_amt) begin
          // Finish with single-cycle steps; residue below one cycle waits
          if (mag >= PERIOD_PS) begin
            adj_c = 3'h1;
          end else begin
            adj_c = 3'h0;
          end
          step_amt = PEND_W'(adj_c) * PERIOD_PS;
        end
        // Step size widened to the period length
        adj_len = {{(INT_W-1){1'b0}}, adj_c};
        len = {2'b00, frdiv_int[g]} + {{(INT_W+1){1'b0}}, carry};
        // Shorter periods advance edges, longer ones delay them
        if (pend[PEND_W-1]) begin
          if (len > adj_len) begin
            len = len - adj_len;
          end else begin
            // Never shorter than one synth cycle
            len = {{(INT_W+1){1'b0}}, 1'b1};
          end
        end else begin
          len = len + adj_len;
        end
        // Integer part of zero still ticks every cycle
        if (len == '0) begin
          len = {{(INT_W+1){1'b0}}, 1'b1};
        end
        // Period boundary: tick, fold fraction, start next count
        if (cnt == '0) begin
          next_tick = 1'b1;
          next_acc = sum[`FDO_FRAC_W-1:0];
          next_cnt = len[INT_W:0] - {{INT_W{1'b0}}, 1'b1};
          // Pending phase moves toward zero by what this period applied
          if (pend[PEND_W-1]) begin
            next_pend = pend + signed'(step_amt);
          end else begin
            next_pend = pend - signed'(step_amt);
          end
        end else begin
          next_cnt = cnt - {{INT_W{1'b0}}, 1'b1};
        end
        // A new request adds to whatever is still pending
        if (frdiv_adj_load[g]) begin
          next_pend = next_pend + PEND_W'(frdiv_adj_ps[g]);
        end
      end

      // Registers only; all decisions sit in the block above
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          cnt <= '0;
          acc <= '0;
          pend <= '0;
          tick <= 1'b0;
        end else begin
          cnt <= next_cnt;
          acc <= next_acc;
          pend <= next_pend;
          tick <= next_tick;
        end
      end

      // Same tick drives output stages and the feedback port
      assign frdiv_tick[g] = tick;
      assign over_hi = pend >= signed'(PERIOD_PS);
      assign over_lo = pend <= -signed'(PERIOD_PS);
      // Sub-cycle residue cannot be applied, so it does not count as busy
      assign frdiv_phase_busy[g] = over_hi || over_lo;
    end
  endgenerate

  // Output paths; paths 2s and 2s+1 form dual stage s
  generate
    for (g = 0; g < `FDO_NUM_PATH; g++) begin : gen_path
      logic tick_in;
      logic [31:0] cnt;
      logic [31:0] next_cnt;
      logic [31:0] pos;
      logic at_end;

      // Active settings, latched at period end
      logic [31:0] act_div;
      logic [31:0] next_div;
      logic [31:0] act_high;
      logic [31:0] next_high;
      logic q;
      logic next_q;
      logic nq;
      logic next_nq;

      assign tick_in = frdiv_tick[path_source(g, stage4_source_select,
                                              stage7_source_select)];

      always_comb begin
        next_cnt = cnt;
        next_div = act_div;
        next_high = act_high;
        next_q = q;
        pos = cnt + 32'h1;
        // Last tick of the active period
        at_end = ({1'b0, cnt} + 33'h1) >= {1'b0, act_div};
        if (tick_in) begin
          if (at_end) begin
            // Settings only change here, so no runt pulse
            next_cnt = `FDO_RST_CNT;
            next_div = out_div[g];
            next_high = out_high[g];
            next_q = path_level(`FDO_RST_CNT, out_div[g], out_high[g]);
          end else begin
            next_cnt = pos;
            // Zero high count gives half period high; else count is high time
            next_q = path_level(pos, act_div, act_high);
          end
        end
        // Duty setting applies whatever the buffer mode
        // Complement follows the new true level, in step with it
        if (out_single_ended[g] && !out_comp_invert[g]) begin
          // Plain copy, noisier but sometimes wanted
          next_nq = next_q;
        end else begin
          next_nq = !next_q;
        end
      end

      // Registers only; pins come straight from flip-flops
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          cnt <= `FDO_RST_CNT;
          act_div <= `FDO_RST_CNT;
          act_high <= `FDO_RST_CNT;
          q <= `FDO_RST_TRUE;
          nq <= `FDO_RST_COMP;
        end else begin
          cnt <= next_cnt;
          act_div <= next_div;
          act_high <= next_high;
          q <= next_q;
          nq <= next_nq;
        end
      end

      assign true_output_pin[g] = q;
      assign complement_output_pin[g] = nq;
    end
  endgenerate

endmodule : fdo_clock_gen

// *** inc/fdo_defines.svh ***
// Constants for the fractional divider and output stage block
`ifndef FDO_DEFINES_SVH
`define FDO_DEFINES_SVH

// Instance counts
`define FDO_NUM_DIV 8
`define FDO_NUM_PATH 12

// Fraction numerator width, denominator is two to this power
`define FDO_FRAC_W 43

// Synthesizer clock period as modelled here
`define FDO_SYNTH_PERIOD_NS 100
`define FDO_SYNTH_PERIOD_PS (`FDO_SYNTH_PERIOD_NS * 1000)

// Period offset per divider cycle during a fine phase step, in synth cycles
`define FDO_STEP_FAST 3'h4
`define FDO_STEP_MED 3'h2
`define FDO_STEP_SLOW 3'h1

// Output path index of the first single stage (stage 4)
`define FDO_FIRST_SINGLE_PATH 8

// Reset values
`define FDO_RST_CNT 32'h0
`define FDO_RST_TRUE 1'b0
`define FDO_RST_COMP 1'b1

`endif

// *** inc/fdo_pkg.sv ***
// Types shared by the fractional divider and output stage block
package fdo_pkg;

  // Fine phase change rate
  typedef enum logic [1:0] {
    FDO_RATE_SLOW,
    FDO_RATE_MED,
    FDO_RATE_FAST
  } fdo_rate_t;

endpackage : fdo_pkg
